/* cer_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - React only in network operation mode
// - Ethernet reaction needs select 3 or interval
// - Serial retry excess native only; loss always
// - Modes 1,2 decelerate; mode 1 faults after
// - Deceleration uses normal decel time
// - Mode 2 re-accelerates when line recovers
// - Mode 6 runs fallback, warns, no fault
// - Torque control with speed limit select 1 uses speed limit instead
// - Mode 6 blocked for panel/serial faults if serial 9999 set
// - Alarm on comm error; option only mode 6
// - Ethernet alarm when select 2 or 3
// - Terminal alarm via function 98 or 198
// - Trip codes HA1 line, HF1 option
// - Fault output asserts signal and alarm bit
// - Enabled fault output commits history
// - Otherwise temporary history, restored on clear
// - Only command-source interface reacts
// - Ethernet setting changes retarget reaction
module cer_ctrl (
    // Clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_nrst,
    // AHB-Lite slave
    input  wire logic               i_hsel,
    input  wire logic [7:0]         i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output logic      [31:0]        o_hrdata,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    // Drive side
    input  wire cer_pkg::cer_err_s  i_err,
    input  wire cer_pkg::cer_drv_s  i_drv,
    input  wire logic [15:0]        i_speed_cmd,
    input  wire logic               i_run_cmd,
    // Reaction outputs
    output logic                    o_output_shutoff,
    output logic                    o_decel_req,
    output logic                    o_reaccel_req,
    output logic [15:0]             o_freq_cmd,
    output logic                    o_run_cmd,
    output logic                    o_freq_override,
    output logic                    o_fault_signal,
    output logic                    o_alarm_bit,
    output logic                    o_fallback_warning,
    output logic [cer_pkg::NUM_TERMS-1:0] o_term,
    output logic [7:0]              o_trip_code,
    output logic                    o_hist_commit,
    output logic                    o_hist_temp
);
    localparam int NT = cer_pkg::NUM_TERMS;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_reg;
    logic [31:0] eth_reg;
    logic [31:0] serial_reg;
    logic [31:0] freq_reg;
    logic [31:0] limit_reg;
    logic [31:0] term0_reg;
    logic [31:0] term1_reg;
    logic [7:0]  hist_reg;
    logic [7:0]  addr_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;

    // Fields
    wire [2:0]  stop_mode        = ctrl_reg[2:0];
    wire [15:0] net_cmd_src_sel  = {ctrl_reg[31:16]};
    wire [1:0]  speed_limit_sel  = ctrl_reg[5:4];
    wire [1:0]  eth_loss_sel     = eth_reg[1:0];
    wire [15:0] eth_check_ival   = eth_reg[31:16];
    wire [15:0] serial_retry_lim = serial_reg[15:0];
    wire [15:0] serial_check_iv  = serial_reg[31:16];
    wire [15:0] fallback_freq    = freq_reg[15:0];
    wire [15:0] fwd_limit        = limit_reg[15:0];
    wire [15:0] rev_limit        = limit_reg[31:16];
    wire [63:0] term_funcs       = {term1_reg, term0_reg};

    // Bus decode
    wire bus_go  = i_hsel && i_hready && i_htrans[1];
    wire bus_wr  = bus_go && i_hwrite;
    wire bus_rd  = bus_go && !i_hwrite;

    ////////////////////////////////////////////////////////////////////////
    // Error qualification
    wire src_ok_pe = !(net_cmd_src_sel == cer_pkg::DISABLED_9999 &&
                       i_drv.option_installed);
    wire eth_en    = (eth_loss_sel == cer_pkg::ETH_LOSS_STOP) ||
                     (eth_check_ival != cer_pkg::DISABLED_9999);
    wire ser_err   = (i_err.line_err_serial_retry &&
                      i_drv.native_protocol) ||
                     i_err.line_err_serial_loss;
    wire pe_line   = (i_err.line_err_panel || ser_err) && src_ok_pe;
    // Settings re-evaluated every cycle so changes retarget at once
    wire eth_line  = i_err.line_err_eth && eth_en && src_ok_pe;
    wire line_err  = pe_line || eth_line || i_err.line_err_option;
    wire opt_fault = i_err.option_internal;
    wire any_err   = (line_err || opt_fault) && i_drv.net_mode;
    wire ser_dis   = (serial_retry_lim == cer_pkg::DISABLED_9999) ||
                     (serial_check_iv == cer_pkg::DISABLED_9999);
    wire fb_ok     = !(ser_dis && pe_line && !opt_fault);

    wire alarm_now = i_drv.net_mode &&
        (pe_line || i_err.line_err_option || i_drv.usb_err ||
         (opt_fault && stop_mode == cer_pkg::STOP_FALLBACK) ||
         (i_err.line_err_eth &&
          (eth_loss_sel == cer_pkg::ETH_LOSS_ALARM ||
           eth_loss_sel == cer_pkg::ETH_LOSS_STOP)));

    wire [7:0] trip_now = opt_fault ? cer_pkg::FAULT_DATA_HF1 :
                          cer_pkg::FAULT_DATA_HA1;

    ////////////////////////////////////////////////////////////////////////
    // Reaction state machine
    cer_pkg::cer_state_e state_reg, state_next;
    logic opt_seen_reg;
    logic fault_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cer_pkg::ST_RUN: begin
                if (any_err) begin
                    case (stop_mode)
                        cer_pkg::STOP_SHUTOFF:
                            state_next = cer_pkg::ST_SHUTOFF;
                        cer_pkg::STOP_DECEL,
                        cer_pkg::STOP_DECEL_RST:
                            state_next = cer_pkg::ST_DECEL;
                        cer_pkg::STOP_FALLBACK:
                            state_next = fb_ok ? cer_pkg::ST_FALLBACK
                                               : cer_pkg::ST_RUN;
                        default: state_next = cer_pkg::ST_RUN;
                    endcase
                end
            end
            cer_pkg::ST_DECEL: begin
                if (!any_err && stop_mode == cer_pkg::STOP_DECEL_RST &&
                    !opt_seen_reg)
                    state_next = cer_pkg::ST_RUN;
                else if (i_drv.motor_stopped)
                    state_next = cer_pkg::ST_STOPPED;
            end
            cer_pkg::ST_STOPPED: begin
                // Mode 2 line fault clears back to normal
                if (!any_err && stop_mode == cer_pkg::STOP_DECEL_RST &&
                    !opt_seen_reg)
                    state_next = cer_pkg::ST_RUN;
            end
            cer_pkg::ST_FALLBACK: begin
                // Option fault keeps fallback after removal
                if (!any_err && !opt_seen_reg)
                    state_next = cer_pkg::ST_RUN;
            end
            cer_pkg::ST_SHUTOFF: state_next = cer_pkg::ST_SHUTOFF;
            default: state_next = cer_pkg::ST_RUN;
        endcase
    end

    wire fault_next = (state_next == cer_pkg::ST_SHUTOFF) ||
        (state_next == cer_pkg::ST_STOPPED &&
         (stop_mode == cer_pkg::STOP_DECEL || opt_seen_reg));
    wire temp_next  = !fault_next &&
        (state_next == cer_pkg::ST_STOPPED);
    wire lim_sel    = i_drv.torque_ctrl &&
                      speed_limit_sel == cer_pkg::SPD_LIM_SET;
    // Reverse limit used when command sign bit set
    wire [15:0] lim_val = i_speed_cmd[15] ? rev_limit : fwd_limit;
    wire [15:0] fb_val  = lim_sel ? lim_val : fallback_freq;
    wire fb_next    = state_next == cer_pkg::ST_FALLBACK;

    logic [15:0] prior_speed_reg;
    logic        prior_run_reg;
    logic        prev_fault_reg;
    logic [7:0]  trip_reg;

    wire [NT-1:0] term_hit;
    wire [NT-1:0] term_neg;
    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_term
            assign term_hit[g] =
                term_funcs[g*8 +: 8] == cer_pkg::TERM_FUNC_POS;
            assign term_neg[g] =
                term_funcs[g*8 +: 8] == cer_pkg::TERM_FUNC_NEG;
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg          <= cer_pkg::ST_RUN;
            opt_seen_reg       <= 1'b0;
            fault_reg          <= 1'b0;
            prev_fault_reg     <= 1'b0;
            prior_speed_reg    <= 16'h0000;
            prior_run_reg      <= 1'b0;
            trip_reg           <= cer_pkg::FAULT_DATA_NONE;
            o_output_shutoff   <= 1'b0;
            o_decel_req        <= 1'b0;
            o_reaccel_req      <= 1'b0;
            o_freq_cmd         <= 16'h0000;
            o_run_cmd          <= 1'b0;
            o_freq_override    <= 1'b0;
            o_fault_signal     <= 1'b0;
            o_alarm_bit        <= 1'b0;
            o_fallback_warning <= 1'b0;
            o_term             <= '0;
            o_trip_code        <= cer_pkg::FAULT_DATA_NONE;
            o_hist_commit      <= 1'b0;
            o_hist_temp        <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == cer_pkg::ST_RUN && state_next != state_reg)
                trip_reg <= trip_now;
            // Option fault sticks until the next recovery to run
            opt_seen_reg <= (state_next == cer_pkg::ST_RUN) ? 1'b0 :
                            (opt_seen_reg || (opt_fault && any_err));
            if (state_reg == cer_pkg::ST_RUN && !any_err) begin
                prior_speed_reg <= i_speed_cmd;
                prior_run_reg   <= i_run_cmd;
            end
            fault_reg          <= fault_next;
            prev_fault_reg     <= fault_reg;
            o_output_shutoff   <= state_next == cer_pkg::ST_SHUTOFF;
            o_decel_req        <= state_next == cer_pkg::ST_DECEL;
            o_reaccel_req      <= state_reg == cer_pkg::ST_DECEL &&
                                  state_next == cer_pkg::ST_RUN;
            o_freq_cmd         <= fb_next ? fb_val : prior_speed_reg;
            o_run_cmd          <= prior_run_reg;
            o_freq_override    <= fb_next;
            o_fallback_warning <= fb_next;
            o_fault_signal     <= fault_next;
            o_alarm_bit        <= fault_next;
            o_term             <= (term_hit & {NT{alarm_now}}) |
                                  (term_neg & {NT{!alarm_now}});
            o_trip_code        <= (fault_next || temp_next) ?
                                  trip_reg : cer_pkg::FAULT_DATA_NONE;
            o_hist_commit      <= fault_reg && !prev_fault_reg;
            o_hist_temp        <= temp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, writes zero wait, reads one wait state
    wire [31:0] status_word = {16'h0000, trip_reg, 3'h0,
                               o_fallback_warning, o_fault_signal,
                               2'h0, 1'(state_reg)};
    wire [31:0] rd_mux =
        (addr_reg == cer_pkg::ADDR_CTRL)   ? ctrl_reg   :
        (addr_reg == cer_pkg::ADDR_ETH)    ? eth_reg    :
        (addr_reg == cer_pkg::ADDR_SERIAL) ? serial_reg :
        (addr_reg == cer_pkg::ADDR_FREQ)   ? freq_reg   :
        (addr_reg == cer_pkg::ADDR_LIMIT)  ? limit_reg  :
        (addr_reg == cer_pkg::ADDR_TERM0)  ? term0_reg  :
        (addr_reg == cer_pkg::ADDR_TERM1)  ? term1_reg  :
        (addr_reg == cer_pkg::ADDR_STATUS) ? status_word :
        (addr_reg == cer_pkg::ADDR_HIST)   ? {24'h0, hist_reg} :
        32'h0000_0000;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_reg    <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            if (bus_go)
                addr_reg <= i_haddr;
            wr_pend_reg <= bus_wr;
            rd_pend_reg <= bus_rd;
            // Wait state lets registered read data stand at the last edge
            o_hreadyout <= !bus_rd;
            o_hresp     <= 1'b0;
            if (rd_pend_reg)
                o_hrdata <= rd_mux;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg   <= cer_pkg::CTRL_RESET;
            eth_reg    <= cer_pkg::ETH_RESET;
            serial_reg <= cer_pkg::SERIAL_RESET;
            freq_reg   <= cer_pkg::ZERO_RESET;
            limit_reg  <= cer_pkg::ZERO_RESET;
            term0_reg  <= cer_pkg::TERM_RESET;
            term1_reg  <= cer_pkg::TERM_RESET;
            hist_reg   <= cer_pkg::FAULT_DATA_NONE;
        end else begin
            if (wr_pend_reg) begin
                case (addr_reg)
                    cer_pkg::ADDR_CTRL:   ctrl_reg   <= i_hwdata;
                    cer_pkg::ADDR_ETH:    eth_reg    <= i_hwdata;
                    cer_pkg::ADDR_SERIAL: serial_reg <= i_hwdata;
                    cer_pkg::ADDR_FREQ:   freq_reg   <= i_hwdata;
                    cer_pkg::ADDR_LIMIT:  limit_reg  <= i_hwdata;
                    cer_pkg::ADDR_TERM0:  term0_reg  <= i_hwdata;
                    cer_pkg::ADDR_TERM1:  term1_reg  <= {8'h00,
                                                         i_hwdata[23:0]};
                    default: ;
                endcase
            end
            // History is written only on a fault commit; the bus cannot write it
            if (fault_reg && !prev_fault_reg)
                hist_reg <= trip_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_shutoff_latch;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_output_shutoff |=> o_output_shutoff && o_fault_signal;
    endproperty
    a_shutoff_latch: assert property (p_shutoff_latch)
        else $error("shutoff or fault released");

    property p_net_only;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_reg == cer_pkg::ST_RUN && !i_drv.net_mode)
        |=> state_reg == cer_pkg::ST_RUN;
    endproperty
    a_net_only: assert property (p_net_only)
        else $error("reaction outside network mode");

    property p_fallback_nofault;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_fallback_warning |-> !o_fault_signal && o_freq_override;
    endproperty
    a_fallback_nofault: assert property (p_fallback_nofault)
        else $error("fallback with fault signal");

    property p_mode2_nofault;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (stop_mode == cer_pkg::STOP_DECEL_RST && !opt_seen_reg &&
         state_reg == cer_pkg::ST_STOPPED) |-> !fault_reg;
    endproperty
    a_mode2_nofault: assert property (p_mode2_nofault)
        else $error("mode 2 raised fault");

    property p_fault_pair;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_fault_signal == o_alarm_bit;
    endproperty
    a_fault_pair: assert property (p_fault_pair)
        else $error("fault signal and alarm bit differ");

    property p_hist_commit;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(fault_reg) |=> o_hist_commit ##1 !o_hist_commit;
    endproperty
    a_hist_commit: assert property (p_hist_commit)
        else $error("history commit not one pulse");

    property p_src_block;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!src_ok_pe && !i_err.line_err_option && !opt_fault &&
         state_reg == cer_pkg::ST_RUN) |=> state_reg == cer_pkg::ST_RUN;
    endproperty
    a_src_block: assert property (p_src_block)
        else $error("blocked interface reacted");

    property p_trip_code;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_reg == cer_pkg::ST_RUN && state_next != cer_pkg::ST_RUN
         && opt_fault) |=> trip_reg == cer_pkg::FAULT_DATA_HF1;
    endproperty
    a_trip_code: assert property (p_trip_code)
        else $error("option trip code wrong");

endmodule

/* cer_pkg.sv */
package cer_pkg;

    // Stop mode codes
    localparam logic [2:0] STOP_SHUTOFF    = 3'h0;
    localparam logic [2:0] STOP_DECEL      = 3'h1;
    localparam logic [2:0] STOP_DECEL_RST  = 3'h2;
    localparam logic [2:0] STOP_FALLBACK   = 3'h6;

    // Setting values
    localparam logic [15:0] DISABLED_9999   = 16'h270f;
    localparam logic [1:0]  ETH_LOSS_ALARM  = 2'h2;
    localparam logic [1:0]  ETH_LOSS_STOP   = 2'h3;
    localparam logic [1:0]  PANEL_SRC_BLOCK = 2'h2;
    localparam logic [1:0]  SPD_LIM_SET     = 2'h1;
    localparam logic [7:0]  TERM_FUNC_POS   = 8'h62;
    localparam logic [7:0]  TERM_FUNC_NEG   = 8'hc6;
    localparam int          NUM_TERMS       = 7;

    // Fault data codes
    localparam logic [7:0]  FAULT_DATA_HA1  = 8'ha1;
    localparam logic [7:0]  FAULT_DATA_HF1  = 8'hf1;
    localparam logic [7:0]  FAULT_DATA_NONE = 8'h00;

    // Register bus map
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_ETH     = 8'h04;
    localparam logic [7:0] ADDR_SERIAL  = 8'h08;
    localparam logic [7:0] ADDR_FREQ    = 8'h0c;
    localparam logic [7:0] ADDR_LIMIT   = 8'h10;
    localparam logic [7:0] ADDR_TERM0   = 8'h14;
    localparam logic [7:0] ADDR_TERM1   = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1c;
    localparam logic [7:0] ADDR_HIST    = 8'h20;

    // Reset values
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] ETH_RESET    = 32'h270f_0000;
    localparam logic [31:0] SERIAL_RESET = 32'h270f_270f;
    localparam logic [31:0] ZERO_RESET   = 32'h0000_0000;
    localparam logic [31:0] TERM_RESET   = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SHUTOFF,
        ST_DECEL,
        ST_STOPPED,
        ST_FALLBACK
    } cer_state_e;

    typedef struct packed {
        logic line_err_panel;
        logic line_err_eth;
        logic line_err_serial_retry;
        logic line_err_serial_loss;
        logic line_err_option;
        logic option_internal;
    } cer_err_s;

    typedef struct packed {
        logic       net_mode;
        logic       option_installed;
        logic       native_protocol;
        logic       torque_ctrl;
        logic       motor_stopped;
        logic       usb_err;
    } cer_drv_s;

endpackage

/* cer_link_model.sv */
`timescale 1ns/1ps
module cer_link_model (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    // Requested fault levels and link delay
    input  wire cer_pkg::cer_err_s i_req,
    input  wire logic [3:0]        i_lag,
    // Fault levels seen by the drive
    output cer_pkg::cer_err_s      o_err
);
    logic [3:0] cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Slow links report a change only after i_lag cycles
    // Host may select command source 9999, so the drive can block panel faults
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= 4'h0;
            o_err   <= '0;
        end else if (i_req == o_err) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg >= i_lag) begin
            cnt_reg <= 4'h0;
            o_err   <= i_req;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

/* test_comm_error_response_ctrl.sv */
`timescale 1ns/1ps
module test_comm_error_response_ctrl;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              hsel = 1'b0;
    logic [7:0]        haddr = 8'h00;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = 32'h0;
    logic [31:0]       hrdata;
    logic              hrdy, hresp;
    cer_pkg::cer_err_s req = '0;
    cer_pkg::cer_err_s err;
    cer_pkg::cer_drv_s drv = '0;
    logic [3:0]        lag = 4'h0;
    logic [15:0]       spd = 16'h0;
    logic [15:0]       fcmd, fb;
    logic [7:0]        trip;
    logic [6:0]        term;
    logic              shut, decel, reacc, ovr, fault, abit, warn, runo;
    logic              hcom, htmp, seen, fx;
    logic [31:0]       rd;
    logic [1:0]        r, ethsel;
    logic              ethiv9, ser9, src9, lim;
    int                k, mode, esel;
    int                fail_count = 0;
    int                compares = 0;
    int                modes[4] = '{0, 1, 2, 6};

    always #5 clk = ~clk;

    cer_link_model link_u (.i_sys_clk(clk), .i_nrst(nrst), .i_req(req),
        .i_lag(lag), .o_err(err));

    cer_ctrl dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_err(err), .i_drv(drv), .i_speed_cmd(spd), .i_run_cmd(1'b1),
        .o_output_shutoff(shut), .o_decel_req(decel), .o_reaccel_req(reacc),
        .o_freq_cmd(fcmd), .o_run_cmd(runo), .o_freq_override(ovr),
        .o_fault_signal(fault), .o_alarm_bit(abit),
        .o_fallback_warning(warn), .o_term(term), .o_trip_code(trip),
        .o_hist_commit(hcom), .o_hist_temp(htmp));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for an edge with hready high
    task automatic edge_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                give_verdict();
            end
            @(posedge clk);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        edge_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        req <= '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
    endtask

    // Link delay is random, so wait on the model before the fixed lag
    task automatic settle();
        int n;
        // Skip the edge that takes the new request
        @(posedge clk);
        for (n = 0; n < 40 && err !== req; n++) @(posedge clk);
        if (err !== req) begin
            fail_count++;
            give_verdict();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 0 none, 1 shutoff, 2 decelerate, 3 fallback
    function automatic logic [1:0] react();
        logic q;
        q = drv.net_mode;
        // Serial errors arrive on the operator port as well
        if (esel < 4 && src9 && drv.option_installed) q = 1'b0;
        if (esel == 1 && ethsel != 2'h3 && ethiv9) q = 1'b0;
        if (esel == 2 && !drv.native_protocol) q = 1'b0;
        if (mode == 6 && esel inside {0, 2, 3} && ser9) q = 1'b0;
        if (!q) return 2'h0;
        return mode == 0 ? 2'h1 : (mode == 6 ? 2'h3 : 2'h2);
    endfunction

    function automatic logic lf();
        if (drv.usb_err) return 1'b1;
        case (esel)
            1: return ethsel[1];
            2: return drv.native_protocol;
            5: return mode == 6;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [15:0] exp_fb();
        if (drv.torque_ctrl && lim) return spd[15] ? 16'h0bbb : 16'h0aaa;
        return fb;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(87));
        do_reset();
        xfer(1'b1, 8'h40, 32'hffff_ffff);
        xfer(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, cer_pkg::ADDR_ETH, 32'h0);
        chk(rd, 32'h270f_0000);
        xfer(1'b0, cer_pkg::ADDR_SERIAL, 32'h0);
        chk(rd, 32'h270f_270f);
        for (k = 0; k < 40; k++) begin
            do_reset();
            mode = modes[$urandom_range(3)];
            esel = $urandom_range(5);
            ethsel = 2'($urandom_range(3));
            {ethiv9, ser9, src9, lim} = 4'($urandom);
            fb = 16'($urandom);
            spd <= 16'($urandom);
            lag <= 4'($urandom_range(3));
            drv <= {$urandom_range(3) != 0, 3'($urandom), 1'b0,
                    1'($urandom)};
            xfer(1'b1, cer_pkg::ADDR_CTRL,
                 {src9 ? 16'h270f : 16'h0, 10'h0, 1'b0, lim, 1'b0, 3'(mode)});
            xfer(1'b1, cer_pkg::ADDR_ETH,
                 {ethiv9 ? 16'h270f : 16'h0064, 14'h0, ethsel});
            xfer(1'b1, cer_pkg::ADDR_SERIAL, ser9 ? 32'h270f_270f : 32'ha000a);
            xfer(1'b1, cer_pkg::ADDR_FREQ, {16'h0, fb});
            xfer(1'b1, cer_pkg::ADDR_LIMIT, 32'h0bbb_0aaa);
            xfer(1'b1, cer_pkg::ADDR_TERM0, 32'h0000_c662);
            req <= cer_pkg::cer_err_s'(6'h20 >> esel);
            settle();
            r = react();
            chk(shut, r == 2'h1);
            chk(decel, r == 2'h2);
            chk(warn, r == 2'h3);
            chk(fault, r == 2'h1);
            chk(abit, r == 2'h1);
            chk(ovr, r == 2'h3);
            chk(runo, 1'b1);
            if (r == 2'h3) chk(fcmd, exp_fb());
            if (drv.net_mode && !(esel < 4 && src9 && drv.option_installed))
                chk(term[1:0], {~lf(), lf()});
            drv.motor_stopped <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            fx = r == 2'h1 || (r == 2'h2 && (mode == 1 || esel == 5));
            chk(fault, fx);
            chk(htmp, r == 2'h2 && !fx);
            chk(hcom, r == 2'h2 && fx);
            if (fx && esel > 3) begin
                chk(trip, esel == 4 ? 8'ha1 : 8'hf1);
                xfer(1'b0, cer_pkg::ADDR_HIST, 32'h0);
                chk(rd, esel == 4 ? 32'ha1 : 32'hf1);
            end
            req <= '0;
            settle();
            chk(fault, fx);
            chk(shut, r == 2'h1);
            chk(warn, r == 2'h3 && esel == 5);
        end
        // Clearing mid-deceleration restarts line faults only
        foreach (modes[i]) begin
            if (i < 2) begin
                do_reset();
                esel = i * 5;
                drv <= 6'h20;
                xfer(1'b1, cer_pkg::ADDR_CTRL, 32'h2);
                req <= cer_pkg::cer_err_s'(6'h20 >> esel);
                settle();
                chk(decel, 1'b1);
                req <= '0;
                seen = 1'b0;
                repeat (20) begin
                    @(posedge clk);
                    #1 seen = seen | reacc;
                end
                chk(seen, esel == 0);
                xfer(1'b0, cer_pkg::ADDR_HIST, 32'h0);
                if (esel == 0) chk(rd, 32'h0);
            end
        end
        give_verdict();
    end
endmodule
